// ==== common/dpsm_defines.svh ====
`ifndef DPSM_DEFINES_SVH
`define DPSM_DEFINES_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define DPSM_CTRL_OFS      8'h00
`define DPSM_STAT_OFS      8'h04
`define DPSM_CFG_OFS       8'h08
`define DPSM_EVT_OFS       8'h0C
`define DPSM_SD_OFS        8'h10

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define DPSM_CW_FAULT_ACK  7
`define DPSM_CFG_NET_RUN   0
`define DPSM_CFG_QS_LSB    8
`define DPSM_CFG_SD_LSB    16
`define DPSM_EVT_INIT_DONE 0
`define DPSM_EVT_DRV_ERR   1
`define DPSM_EVT_STOPPED   2
`define DPSM_EVT_FR_DONE   3

// ------------------------------------------------------------
// reset values and codes
// ------------------------------------------------------------
`define DPSM_CTRL_RST      16'h0000
`define DPSM_QS_RST        16'h0002
`define DPSM_SD_RST        16'h0001
`define DPSM_QS_STAY       16'h0005
// status low byte per state; bit 6 is switch-on disabled
`define DPSM_SW_NOTRDY     7'h00
`define DPSM_SW_DISABLED   7'h40
`define DPSM_SW_READY      7'h21
`define DPSM_SW_ON         7'h23
`define DPSM_SW_OPEN       7'h27
`define DPSM_SW_QSTOP      7'h07
`define DPSM_SW_FREACT     7'h0F
`define DPSM_SW_FAULT      7'h08

`endif

// ==== common/dpsm_pkg.sv ====
package dpsm_pkg;

  typedef enum logic [2:0] {
    S_NOT_READY,
    S_SW_DISABLED,
    S_READY,
    S_SWITCHED_ON,
    S_OP_ENABLED,
    S_QUICK_STOP,
    S_FAULT_REACT,
    S_FAULT
  } dpsm_state_type;

  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] qs_code;
    logic [15:0] sd_code;
    logic        net_run;
  } dpsm_cfg_type;

  typedef struct packed {
    logic        stage_on;
    logic        motion_en;
    logic        stop_fast;
    logic        stop_quick;
    logic        stop_shut;
  } dpsm_drive_type;

endpackage : dpsm_pkg

// ==== rtl/dpsm_core.sv ====
`timescale 1ns/10ps
`include "dpsm_defines.svh"
// Summary of operation
// - commands only taken while network running
// - don't-care bits ignored when decoding
// - reset enters not ready, status 0000
// - init done enters switch-on disabled
// - ready to switch on reports 0001
// - switched on reports 0011, stage on
// - operation enabled reports 0111, motion allowed
// - quick stop reports 0111, holds on code 5
// - fault reaction reports 1111
// - fault reports 1000 after handling
// - drive error enters fault reaction
// - shutdown moves to ready to switch on
// - shutdown in operation sets stop_shut, shutdown code unused
// - switch on moves ready to switched on
// - enable operation moves to operation enabled
// - disable operation returns to switched on
// - quick stop in ready disables switch-on
// - switched on disable or quick stop
// - disable voltage in operation stops fast
// - quick stop in operation enters quick stop
// - quick stop exits unless code 5
// - rising control bit 7 clears fault

module dpsm_core (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  // ahb-lite slave
  input  wire logic                  hsel,
  input  wire logic [7:0]            haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic      [31:0]           hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  // drive events
  input  wire logic                  init_done,
  input  wire logic                  drive_error,
  input  wire logic                  motion_stopped,
  input  wire logic                  fault_handled,
  // drive controls
  output dpsm_pkg::dpsm_drive_type   drive_ctl,
  output logic      [15:0]           drive_status_word
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    dpsm_pkg::dpsm_state_type st;
    dpsm_pkg::dpsm_cfg_type   cfg;
    dpsm_pkg::dpsm_drive_type drv;
    logic [15:0]              sw;
    logic                     cw7_prev;
    logic [3:0]               evt;
    logic [31:0]              rdata;
    logic                     wr_pend;
    logic [7:0]               wr_addr;
  } dpsm_core_type;

  dpsm_core_type s_r;
  dpsm_core_type s_nxt;

  function automatic logic [6:0] state_bits(
    input dpsm_pkg::dpsm_state_type st);
    case (st)
      dpsm_pkg::S_NOT_READY:   state_bits = `DPSM_SW_NOTRDY;
      dpsm_pkg::S_SW_DISABLED: state_bits = `DPSM_SW_DISABLED;
      dpsm_pkg::S_READY:       state_bits = `DPSM_SW_READY;
      dpsm_pkg::S_SWITCHED_ON: state_bits = `DPSM_SW_ON;
      dpsm_pkg::S_OP_ENABLED:  state_bits = `DPSM_SW_OPEN;
      dpsm_pkg::S_QUICK_STOP:  state_bits = `DPSM_SW_QSTOP;
      dpsm_pkg::S_FAULT_REACT: state_bits = `DPSM_SW_FREACT;
      default:                 state_bits = `DPSM_SW_FAULT;
    endcase
  endfunction : state_bits

  function automatic dpsm_pkg::dpsm_drive_type drive_of(
    input dpsm_pkg::dpsm_state_type st);
    drive_of = '0;
    drive_of.stage_on  = (st == dpsm_pkg::S_SWITCHED_ON) ||
                         (st == dpsm_pkg::S_OP_ENABLED) ||
                         (st == dpsm_pkg::S_QUICK_STOP);
    drive_of.motion_en = (st == dpsm_pkg::S_OP_ENABLED);
    drive_of.stop_quick = (st == dpsm_pkg::S_QUICK_STOP);
  endfunction : drive_of

  // ------------------------------------------------------------
  // command decode
  // ------------------------------------------------------------
  logic [15:0] cw;
  logic        cmd_ok;
  logic        c_shut;
  logic        c_on;
  logic        c_enop;
  logic        c_qs;
  logic        c_dv;
  logic        qs_hold;

  always_comb begin
    cw      = s_r.cfg.ctrl;
    cmd_ok  = s_r.cfg.net_run && !cw[`DPSM_CW_FAULT_ACK];
    c_shut  = cmd_ok && (cw[2:0] == 3'h6);
    c_on    = cmd_ok && (cw[3:0] == 4'h7);
    c_enop  = cmd_ok && (cw[3:0] == 4'hF);
    c_qs    = cmd_ok && (cw[2:1] == 2'h1);
    c_dv    = cmd_ok && !cw[1];
    qs_hold = (s_r.cfg.qs_code == `DPSM_QS_STAY);
  end

  // ------------------------------------------------------------
  // next state, bus and status
  // ------------------------------------------------------------
  logic addr_ph;
  logic [7:0] a;

  always_comb begin
    s_nxt = s_r;
    addr_ph = hsel && hready && htrans[1];
    a = s_r.wr_addr;
    // sticky events; set wins over a clear in the same cycle
    if (s_r.wr_pend && a == `DPSM_EVT_OFS) begin
      s_nxt.evt = s_r.evt & ~hwdata[3:0];
    end
    if (s_r.wr_pend && a == `DPSM_CTRL_OFS) begin
      s_nxt.cfg.ctrl = hwdata[15:0];
    end else if (s_r.wr_pend && a == `DPSM_CFG_OFS) begin
      s_nxt.cfg.net_run = hwdata[`DPSM_CFG_NET_RUN];
      s_nxt.cfg.qs_code = hwdata[`DPSM_CFG_QS_LSB +: 16];
    end else if (s_r.wr_pend && a == `DPSM_SD_OFS) begin
      s_nxt.cfg.sd_code = hwdata[15:0];
    end
    s_nxt.evt[`DPSM_EVT_DRV_ERR]  = s_nxt.evt[`DPSM_EVT_DRV_ERR] |
                                    drive_error;
    s_nxt.evt[`DPSM_EVT_STOPPED]  = s_nxt.evt[`DPSM_EVT_STOPPED] |
                                    motion_stopped;
    s_nxt.cw7_prev = cw[`DPSM_CW_FAULT_ACK];

    case (s_r.st)
      dpsm_pkg::S_NOT_READY: begin
        if (init_done) begin
          s_nxt.st = dpsm_pkg::S_SW_DISABLED;
          s_nxt.evt[`DPSM_EVT_INIT_DONE] = 1'b1;
        end else if (c_shut) begin
          s_nxt.st = dpsm_pkg::S_READY;
        end
      end
      dpsm_pkg::S_SW_DISABLED: begin
        if (c_shut) begin
          s_nxt.st = dpsm_pkg::S_READY;
        end
      end
      dpsm_pkg::S_READY: begin
        if (c_qs) begin
          s_nxt.st = dpsm_pkg::S_SW_DISABLED;
        end else if (c_on) begin
          s_nxt.st = dpsm_pkg::S_SWITCHED_ON;
        end
      end
      dpsm_pkg::S_SWITCHED_ON: begin
        if (c_dv || c_qs) begin
          s_nxt.st = dpsm_pkg::S_SW_DISABLED;
        end else if (c_shut) begin
          s_nxt.st = dpsm_pkg::S_READY;
        end else if (c_enop) begin
          s_nxt.st = dpsm_pkg::S_OP_ENABLED;
        end
      end
      dpsm_pkg::S_OP_ENABLED: begin
        if (c_dv) begin
          s_nxt.st = dpsm_pkg::S_SW_DISABLED;
          s_nxt.drv.stop_fast = 1'b1;
        end else if (c_qs) begin
          s_nxt.st = dpsm_pkg::S_QUICK_STOP;
        end else if (c_shut) begin
          s_nxt.st = dpsm_pkg::S_READY;
          s_nxt.drv.stop_shut = 1'b1;
        end else if (c_on) begin
          s_nxt.st = dpsm_pkg::S_SWITCHED_ON;
        end
      end
      dpsm_pkg::S_QUICK_STOP: begin
        // leave only when code is not 5
        if (!qs_hold && (motion_stopped || c_dv)) begin
          s_nxt.st = dpsm_pkg::S_SW_DISABLED;
        end
      end
      dpsm_pkg::S_FAULT_REACT: begin
        if (fault_handled) begin
          s_nxt.st = dpsm_pkg::S_FAULT;
          s_nxt.evt[`DPSM_EVT_FR_DONE] = 1'b1;
        end
      end
      default: begin
        // rising edge of control bit 7
        if (s_r.cfg.net_run && cw[`DPSM_CW_FAULT_ACK] && !s_r.cw7_prev) begin
          s_nxt.st = dpsm_pkg::S_SW_DISABLED;
        end
      end
    endcase
    // other control values fall through unchanged

    if (drive_error && s_r.st != dpsm_pkg::S_NOT_READY &&
        s_r.st != dpsm_pkg::S_FAULT_REACT && s_r.st != dpsm_pkg::S_FAULT) begin
      s_nxt.st = dpsm_pkg::S_FAULT_REACT;
    end

    // fast/shutdown stop held only while the drive still moves
    if (s_nxt.st != s_r.st) begin
      s_nxt.drv = drive_of(s_nxt.st);
      s_nxt.drv.stop_fast = (s_r.st == dpsm_pkg::S_OP_ENABLED) &&
                            (s_nxt.st == dpsm_pkg::S_SW_DISABLED) && c_dv;
      s_nxt.drv.stop_shut = (s_r.st == dpsm_pkg::S_OP_ENABLED) &&
                            (s_nxt.st == dpsm_pkg::S_READY);
    end else if (motion_stopped) begin
      s_nxt.drv.stop_fast = 1'b0;
      s_nxt.drv.stop_shut = 1'b0;
    end

    // status bits follow state in same edge
    s_nxt.sw = {9'h000, state_bits(s_nxt.st)};

    // ahb-lite read data prepared in address phase
    s_nxt.wr_pend = addr_ph && hwrite;
    s_nxt.wr_addr = haddr;
    if (addr_ph && !hwrite) begin
      if (haddr == `DPSM_CTRL_OFS) begin
        s_nxt.rdata = {16'h0000, s_r.cfg.ctrl};
      end else if (haddr == `DPSM_STAT_OFS) begin
        s_nxt.rdata = {16'h0000, s_r.sw};
      end else if (haddr == `DPSM_CFG_OFS) begin
        // only the low byte of the option code reads back
        s_nxt.rdata = {16'h0000, s_r.cfg.qs_code[7:0],
                       7'h00, s_r.cfg.net_run};
      end else if (haddr == `DPSM_EVT_OFS) begin
        s_nxt.rdata = {28'h0000000, s_r.evt};
      end else if (haddr == `DPSM_SD_OFS) begin
        s_nxt.rdata = {16'h0000, s_r.cfg.sd_code};
      end else begin
        s_nxt.rdata = 32'h00000000;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r          <= '0;
      s_r.st       <= dpsm_pkg::S_NOT_READY;
      s_r.cfg.ctrl <= `DPSM_CTRL_RST;
      s_r.cfg.qs_code <= `DPSM_QS_RST;
      s_r.cfg.sd_code <= `DPSM_SD_RST;
      s_r.sw       <= {9'h000, `DPSM_SW_NOTRDY};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign hrdata            = s_r.rdata;
  assign hreadyout         = 1'b1;
  assign hresp             = 1'b0;
  assign drive_ctl         = s_r.drv;
  assign drive_status_word = s_r.sw;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  // not ready bits
  status_notrdy_a: assert property (@(posedge clk)
    disable iff (!rst_b)
    s_r.st == dpsm_pkg::S_NOT_READY |-> s_r.sw[6:0] == 7'h00)
    else $error("not ready status wrong");
  init_done_a: assert property (@(posedge clk) disable iff (!rst_b)
    s_r.st == dpsm_pkg::S_NOT_READY && init_done && !drive_error
    |=> s_r.st == dpsm_pkg::S_SW_DISABLED && s_r.sw[6])
    else $error("init did not disable switch-on");
  net_gate_a: assert property (@(posedge clk) disable iff (!rst_b)
    !s_r.cfg.net_run && !drive_error && !init_done && !fault_handled &&
    !motion_stopped |=> $stable(s_r.st))
    else $error("state moved without network running");
  switch_on_a: assert property (@(posedge clk) disable iff (!rst_b)
    s_r.st == dpsm_pkg::S_READY && c_on && !drive_error
    |=> s_r.st == dpsm_pkg::S_SWITCHED_ON && drive_ctl.stage_on)
    else $error("switch on missed");
  drive_err_a: assert property (@(posedge clk) disable iff (!rst_b)
    drive_error && s_r.st inside {dpsm_pkg::S_SW_DISABLED,
    dpsm_pkg::S_READY, dpsm_pkg::S_SWITCHED_ON, dpsm_pkg::S_OP_ENABLED,
    dpsm_pkg::S_QUICK_STOP} |=> s_r.sw[3:0] == 4'hF)
    else $error("drive error not reacted");
  qs_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    s_r.st == dpsm_pkg::S_QUICK_STOP && qs_hold && !drive_error
    |=> s_r.st == dpsm_pkg::S_QUICK_STOP)
    else $error("quick stop left under code 5");
  fault_ack_a: assert property (@(posedge clk) disable iff (!rst_b)
    s_r.st == dpsm_pkg::S_FAULT && s_r.cfg.net_run &&
    $rose(s_r.cfg.ctrl[7]) |=> s_r.sw[6:0] == 7'h40)
    else $error("fault not acknowledged");
  status_track_a: assert property (@(posedge clk)
    disable iff (!rst_b)
    s_r.sw[6:0] == state_bits(s_r.st))
    else $error("status and state disagree");
  shut_on_a: assert property (@(posedge clk) disable iff (!rst_b)
    s_r.st == dpsm_pkg::S_SWITCHED_ON && c_shut && !drive_error
    |=> s_r.st == dpsm_pkg::S_READY)
    else $error("shutdown from switched on missed");
  enable_op_a: assert property (@(posedge clk) disable iff (!rst_b)
    s_r.st == dpsm_pkg::S_SWITCHED_ON && c_enop && !drive_error
    |=> s_r.st == dpsm_pkg::S_OP_ENABLED && drive_ctl.motion_en)
    else $error("enable operation missed");
  disable_op_a: assert property (@(posedge clk) disable iff (!rst_b)
    s_r.st == dpsm_pkg::S_OP_ENABLED && c_on && !drive_error
    |=> s_r.st == dpsm_pkg::S_SWITCHED_ON)
    else $error("disable operation missed");
  qs_ready_a: assert property (@(posedge clk) disable iff (!rst_b)
    s_r.st == dpsm_pkg::S_READY && c_qs && !drive_error
    |=> s_r.st == dpsm_pkg::S_SW_DISABLED)
    else $error("quick stop in ready missed");
  on_off_a: assert property (@(posedge clk) disable iff (!rst_b)
    s_r.st == dpsm_pkg::S_SWITCHED_ON && (c_dv || c_qs) && !drive_error
    |=> s_r.st == dpsm_pkg::S_SW_DISABLED && !drive_ctl.stage_on)
    else $error("switched on did not switch off");
  fast_stop_a: assert property (@(posedge clk) disable iff (!rst_b)
    s_r.st == dpsm_pkg::S_OP_ENABLED && c_dv && !drive_error
    |=> s_r.st == dpsm_pkg::S_SW_DISABLED && drive_ctl.stop_fast)
    else $error("disable voltage did not stop fast");
  qs_enter_a: assert property (@(posedge clk) disable iff (!rst_b)
    s_r.st == dpsm_pkg::S_OP_ENABLED && c_qs && !drive_error
    |=> s_r.st == dpsm_pkg::S_QUICK_STOP && drive_ctl.stop_quick)
    else $error("quick stop not entered");
  shut_stop_a: assert property (@(posedge clk) disable iff (!rst_b)
    s_r.st == dpsm_pkg::S_OP_ENABLED && c_shut && !drive_error
    |=> s_r.st == dpsm_pkg::S_READY && drive_ctl.stop_shut)
    else $error("shutdown in operation missed");
  fault_done_a: assert property (@(posedge clk) disable iff (!rst_b)
    s_r.st == dpsm_pkg::S_FAULT_REACT && fault_handled
    |=> s_r.sw[3:0] == 4'h8)
    else $error("fault state not reached");

endmodule : dpsm_core

// ==== tb/dpsm_plant.sv ====
`timescale 1ns/10ps
module dpsm_plant (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_b,
  // drive side
  input  wire dpsm_pkg::dpsm_drive_type drive_ctl,
  input  wire logic [3:0]               stop_dly,
  output logic                          motion_stopped
);
  logic [3:0] run_cnt_r;

  // ----------------------------------------------------------
  // standstill only after a settling time, so stop states show
  // ----------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      run_cnt_r      <= 4'h0;
      motion_stopped <= 1'b0;
    end else if (drive_ctl.motion_en) begin
      run_cnt_r      <= 4'h0;
      motion_stopped <= 1'b0;
    end else begin
      if (run_cnt_r != 4'hF) run_cnt_r <= run_cnt_r + 4'h1;
      motion_stopped <= (run_cnt_r >= stop_dly);
    end
  end
endmodule : dpsm_plant

// ==== tb/testbench.sv ====
`timescale 1ns/10ps
`include "dpsm_defines.svh"
module testbench;
  logic                     clk, rst_b, hsel, hwrite, hreadyout, hresp;
  logic                     init_done, drive_error, fault_handled;
  logic                     motion_stopped;
  logic [7:0]               haddr;
  logic [1:0]               htrans;
  logic [2:0]               hsize;
  logic [3:0]               stop_dly;
  logic [31:0]              hwdata, hrdata, rd;
  logic [15:0]              drive_status_word, cw;
  dpsm_pkg::dpsm_drive_type drive_ctl;
  dpsm_pkg::dpsm_state_type st;
  int                       err_total, n_tests, i;
  logic [3:0]               tbl [6] = '{4'h6, 4'h7, 4'hF, 4'h2, 4'h0, 4'hE};
  logic [15:0]              dir [20] = '{16'h6, 16'h7, 16'hF, 16'h7, 16'hF,
    16'h6, 16'h2, 16'h6, 16'h7, 16'h2, 16'h6, 16'h7, 16'h0, 16'h6, 16'h7,
    16'hF, 16'h0, 16'h6, 16'h7, 16'hF};

  dpsm_core i_dut (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .init_done(init_done), .drive_error(drive_error),
    .motion_stopped(motion_stopped), .fault_handled(fault_handled),
    .drive_ctl(drive_ctl), .drive_status_word(drive_status_word));
  dpsm_plant i_plant (.clk(clk), .rst_b(rst_b), .drive_ctl(drive_ctl),
    .stop_dly(stop_dly), .motion_stopped(motion_stopped));

  always #50 clk = ~clk;

  // ----------------------------------------------------------
  // checking and closing
  // ----------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop

  // ----------------------------------------------------------
  // bus master, single word transfers
  // ----------------------------------------------------------
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_total++;
      report_and_stop();
    end
  endtask : wait_rdy

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    hsize  <= 3'h2;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask : bus

  task automatic cfg(input logic net, input logic [15:0] qs);
    bus(1'b1, `DPSM_CFG_OFS, {8'h00, qs, 7'h00, net});
  endtask : cfg

  // ----------------------------------------------------------
  // expected behaviour
  // ----------------------------------------------------------
  function automatic logic [15:0] pat(input dpsm_pkg::dpsm_state_type s);
    case (s)
      dpsm_pkg::S_SW_DISABLED: pat = 16'h0040;
      dpsm_pkg::S_READY:       pat = 16'h0021;
      dpsm_pkg::S_SWITCHED_ON: pat = 16'h0023;
      dpsm_pkg::S_OP_ENABLED:  pat = 16'h0027;
      dpsm_pkg::S_QUICK_STOP:  pat = 16'h0007;
      dpsm_pkg::S_FAULT_REACT: pat = 16'h000F;
      dpsm_pkg::S_FAULT:       pat = 16'h0008;
      default:                 pat = 16'h0000;
    endcase
  endfunction : pat

  function automatic dpsm_pkg::dpsm_state_type nx(
    input dpsm_pkg::dpsm_state_type s, input logic [15:0] c);
    logic sd, so, eo, qs, dv;
    sd = c[2:0] == 3'h6;
    so = c[3:0] == 4'h7;
    eo = c[3:0] == 4'hF;
    qs = c[2:1] == 2'h1;
    dv = !c[1];
    nx = s;
    if (!c[7]) begin
      case (s)
        dpsm_pkg::S_SW_DISABLED: if (sd) nx = dpsm_pkg::S_READY;
        dpsm_pkg::S_READY: begin
          if (so) nx = dpsm_pkg::S_SWITCHED_ON;
          else if (qs) nx = dpsm_pkg::S_SW_DISABLED;
        end
        dpsm_pkg::S_SWITCHED_ON: begin
          if (eo) nx = dpsm_pkg::S_OP_ENABLED;
          else if (sd) nx = dpsm_pkg::S_READY;
          else if (dv || qs) nx = dpsm_pkg::S_SW_DISABLED;
        end
        dpsm_pkg::S_OP_ENABLED: begin
          if (so) nx = dpsm_pkg::S_SWITCHED_ON;
          else if (sd) nx = dpsm_pkg::S_READY;
          else if (dv) nx = dpsm_pkg::S_SW_DISABLED;
          else if (qs) nx = dpsm_pkg::S_QUICK_STOP;
        end
        default: ;
      endcase
    end
  endfunction : nx

  // ----------------------------------------------------------
  // stimulus helpers
  // ----------------------------------------------------------
  task automatic wait_sw(input dpsm_pkg::dpsm_state_type s);
    int n;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      #1;
      if (drive_status_word === pat(s)) break;
    end
    chk("status", {16'h0, drive_status_word}, {16'h0, pat(s)});
    @(posedge clk);
  endtask : wait_sw

  // settle first so a wrong late move is still caught
  task automatic cmd(input logic [15:0] c, input dpsm_pkg::dpsm_state_type s);
    bus(1'b1, `DPSM_CTRL_OFS, {16'h0, c});
    repeat (3) @(posedge clk);
    wait_sw(s);
  endtask : cmd

  task automatic pulse(input int k);
    if (k == 0) init_done <= 1'b1;
    if (k == 1) drive_error <= 1'b1;
    if (k == 2) fault_handled <= 1'b1;
    @(posedge clk);
    init_done     <= 1'b0;
    drive_error   <= 1'b0;
    fault_handled <= 1'b0;
  endtask : pulse

  task automatic do_reset;
    rst_b <= 1'b0;
    repeat (20) @(posedge clk);
    chk("rst_sw", {16'h0, drive_status_word}, 32'h0);
    chk("rst_ctl", {27'h0, drive_ctl}, 32'h0);
    rst_b <= 1'b1;
    @(posedge clk);
    chk("nrdy_sw", {16'h0, drive_status_word}, 32'h0);
  endtask : do_reset

  task automatic restart(input logic [15:0] qs);
    do_reset();
    pulse(0);
    wait_sw(dpsm_pkg::S_SW_DISABLED);
    cfg(1'b1, qs);
    st = dpsm_pkg::S_SW_DISABLED;
  endtask : restart

  task automatic run(input logic [15:0] c);
    st = nx(st, c);
    cmd(c, st);
  endtask : run

  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin
    {clk, hsel, hwrite, init_done, drive_error, fault_handled} = 6'h00;
    {haddr, htrans, hsize, hwdata} = 45'h0;
    rst_b     = 1'b0;
    stop_dly  = 4'h8;
    err_total = 0;
    n_tests   = 0;
    void'($urandom(32'h4B34));
    @(posedge clk);
    do_reset();
    cfg(1'b1, 16'h0002);
    cmd(16'h0006, dpsm_pkg::S_READY);
    restart(16'h0002);
    chk("stage_off", drive_ctl.stage_on, 1'b0);
    bus(1'b0, `DPSM_EVT_OFS, 32'h0);
    chk("evt_init", rd & 32'h3, 32'h1);
    bus(1'b1, `DPSM_EVT_OFS, 32'h1);
    bus(1'b0, `DPSM_EVT_OFS, 32'h0);
    chk("evt_clr", rd & 32'h3, 32'h0);
    bus(1'b0, 8'h14, 32'h0);
    chk("unmapped", rd, 32'h0);
    bus(1'b0, `DPSM_STAT_OFS, 32'h0);
    chk("stat_rd", rd, 32'h40);
    chk("hresp", hresp, 1'b0);
    bus(1'b0, `DPSM_CFG_OFS, 32'h0);
    chk("cfg_rd", rd, 32'h00000201);
    bus(1'b0, `DPSM_SD_OFS, 32'h0);
    chk("sd_rd", rd, {16'h0, `DPSM_SD_RST});
    cfg(1'b0, 16'h0002);
    cmd(16'h0006, dpsm_pkg::S_SW_DISABLED);
    cfg(1'b1, 16'h0002);
    for (i = 0; i < 20; i++) begin
      run(dir[i]);
      if (i == 1) chk("stage_on", drive_ctl.stage_on, 1'b1);
      if (i == 2) chk("motion", drive_ctl.motion_en, 1'b1);
      if (i == 5) chk("stop_shut", drive_ctl.stop_shut, 1'b1);
      if (i == 16) chk("stop_fast", drive_ctl.stop_fast, 1'b1);
    end
    cmd(16'h0002, dpsm_pkg::S_QUICK_STOP);
    chk("stop_quick", drive_ctl.stop_quick, 1'b1);
    wait_sw(dpsm_pkg::S_SW_DISABLED);
    st = dpsm_pkg::S_SW_DISABLED;
    for (i = 17; i < 20; i++) run(dir[i]);
    pulse(1);
    wait_sw(dpsm_pkg::S_FAULT_REACT);
    pulse(2);
    wait_sw(dpsm_pkg::S_FAULT);
    bus(1'b0, `DPSM_EVT_OFS, 32'h0);
    chk("evt_err", rd[1], 1'b1);
    cmd(16'h0006, dpsm_pkg::S_FAULT);
    cmd(16'h0080, dpsm_pkg::S_SW_DISABLED);
    st = dpsm_pkg::S_SW_DISABLED;
    cfg(1'b1, 16'h0005);
    for (i = 0; i < 120; i++) begin
      cw       = 16'($urandom);
      cw[3:0]  = tbl[$urandom_range(0, 5)];
      cw[7]    = ($urandom_range(0, 7) == 0);
      stop_dly <= 4'($urandom_range(0, 6));
      run(cw);
      if (st == dpsm_pkg::S_QUICK_STOP) begin
        cmd(16'h0000, dpsm_pkg::S_QUICK_STOP);
        restart(16'h0005);
      end
    end
    report_and_stop();
  end
endmodule : testbench
